// File: verilog/pb_ldo_pkg.sv
/*
  Constants shared by the push-button and auxiliary output control registers:
  register offsets, field positions, reset values, voltage codes and hold times.
  Assumes a 125 MHz system clock.
*/
`default_nettype none
package pb_ldo_pkg;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] SYS_OUT_OFFSET = 8'h06;
  localparam logic [7:0] AUX_OUT_OFFSET = 8'h07;
  localparam logic [7:0] PB_CTRL_OFFSET = 8'h08;

  // Reset values; status bits of push_button_control come up clear
  localparam logic [7:0] SYS_OUT_RESET = 8'hAA;
  localparam logic [7:0] AUX_OUT_RESET = 8'h28;
  localparam logic [7:0] PB_CTRL_RESET = 8'h68;

  // system output control fields
  localparam int SYS_ENABLE_BIT  = 7;
  localparam int SYS_RANGE_LSB   = 5;
  localparam int SYS_CODE_LSB    = 1;

  // aux_output_control fields
  localparam int AUX_ENABLE_BIT  = 7;
  localparam int AUX_CODE_LSB    = 2;
  localparam int AUX_QUAL_BIT    = 0;

  // push_button_control fields
  localparam int FIRST_WAKE_STATUS_SEL_BIT   = 7;
  localparam int SECOND_WAKE_STATUS_SEL_BIT   = 6;
  localparam int RECOVER_BIT     = 5;
  localparam int RESET_SEL_LSB   = 3;
  localparam int PIN_FUNC_BIT    = 2;
  localparam int FIRST_WAKE_STATUS_STAT_BIT  = 1;
  localparam int SECOND_WAKE_STATUS_STAT_BIT  = 0;

  // Writable bit masks
  localparam logic [7:0] SYS_OUT_WMASK = 8'hFE;
  localparam logic [7:0] AUX_OUT_WMASK = 8'hFD;
  localparam logic [7:0] PB_CTRL_WMASK = 8'hFC;

  // System range codes
  localparam logic [1:0] RANGE_LOW    = 2'h0;
  localparam logic [1:0] RANGE_LINEAR = 2'h1;
  localparam logic [1:0] RANGE_FRAC   = 2'h2;
  localparam logic [1:0] RANGE_HIGH   = 2'h3;

  // Voltages in mV
  localparam logic [15:0] SYS_LOW0_MV      = 16'h044C; // 1100
  localparam logic [15:0] SYS_LOW1_MV      = 16'h04B0; // 1200
  localparam logic [15:0] SYS_FRAC_BASE_MV = 16'h04E2; // 1250
  localparam logic [15:0] SYS_FRAC_NUM     = 16'h00FA; // 250 mV per 3 codes
  localparam logic [15:0] SYS_FRAC_DEN     = 16'h0003;
  localparam logic [15:0] SYS_LINEAR_MV    = 16'h0514; // 1300
  localparam logic [15:0] SYS_HIGH_MV      = 16'h0708; // 1800
  localparam logic [15:0] STEP_MV          = 16'h0064; // 100
  localparam logic [15:0] AUX_BASE_MV      = 16'h0320; // 800
  localparam logic [15:0] AUX_PASS_MV      = 16'h0CE4; // 3300

  // Hold times in ms
  localparam logic [15:0] FIRST_WAKE_STATUS_SHORT_MS = 16'h0050; // 80
  localparam logic [15:0] FIRST_WAKE_STATUS_LONG_MS  = 16'h0258; // 600
  localparam logic [15:0] SECOND_WAKE_STATUS_SHORT_MS = 16'h03E8; // 1000
  localparam logic [15:0] SECOND_WAKE_STATUS_LONG_MS  = 16'h05DC; // 1500
  localparam logic [15:0] RESET_5S_MS    = 16'h1388; // 5000
  localparam logic [15:0] RESET_9S_MS    = 16'h2328; // 9000
  localparam logic [15:0] RESET_11S_MS   = 16'h2AF8; // 11000
  localparam logic [15:0] RESET_15S_MS   = 16'h3A98; // 15000

  // Millisecond tick
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

endpackage
`default_nettype wire

// File: verilog/hold_timer.sv
/*
  Counts whole milliseconds of one continuous press and pulses once when the
  count passes the threshold. Assumes a synchronised press level and a tick
  that restarts with each press.
*/
`timescale 1ns/1ns
`default_nettype none
module hold_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             pressed,
  input  wire logic             msTick,
  input  wire logic [CNT_W-1:0] thresholdMs,
  output logic                  reached
);

  logic [CNT_W-1:0] count_q;
  logic             fired_q;
  wire              crossing = pressed && msTick && !fired_q && (count_q == thresholdMs);

  // Release restarts the interval; one pulse per press
  always_ff @(posedge clk) begin
    if (rst || !pressed) begin
      count_q <= '0;
      fired_q <= 1'b0;
      reached <= 1'b0;
    end else begin
      if (msTick && !fired_q)
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (crossing)
        fired_q <= 1'b1;
      reached <= crossing;
    end
  end

endmodule
`default_nettype wire

// File: verilog/pushbutton_ldo_ctrl_regs.sv
/*
  Control and status registers for the system output, the auxiliary output
  and the push-button timers, with their decoded outputs.
  Assumes a register port driven by the serial interface logic on clk,
  and raw pins for the push-button, load-switch control, input-valid and
  power-good signals.
*/
// What this block does
// - Ranges 10 and 11 map nonlinear and linear codes
// - Aux code weights added to 0.8 V
// - Aux code above 3.3 V selects pass-through
// - Aux code applies only while output disabled
// - Reset optionally qualified by valid input voltage
// - First wake hold 80 or 600 ms
// - Second wake hold 1000 or 1500 ms
// - After reset, ship or high-impedance mode
// - Reset hold 5, 9, 11 or 15 s
// - Shared pin shows power-good or push-button
// - Wake status bits set, cleared on read
// - Range 01 gives 1.30 V plus code steps
`timescale 1ns/1ns
`default_nettype none
module pushbutton_ldo_ctrl_regs
  import pb_ldo_pkg::*;
#(
  parameter int TICK_COUNT = pb_ldo_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWdata,
  output logic [7:0]       regRdata,
  input  wire logic        pushButton_n,
  input  wire logic        auxControlPin,
  input  wire logic        inputValid,
  input  wire logic        powerGood_n,
  output logic             sharedPin_n,
  output logic             systemEnable,
  output logic [15:0]      systemVoltageMv,
  output logic             auxOutputOn,
  output logic [15:0]      auxVoltageMv,
  output logic             auxPassThrough,
  output logic             pbReset,
  output logic             shipModeReq,
  output logic             hizModeReq
);

  // Register storage
  logic [7:0]  sysOut_q;
  logic [7:0]  auxOut_q;
  logic [7:0]  pbCtrl_q;
  logic        wake1Stat_q;
  logic        wake2Stat_q;
  logic [4:0]  auxApplied_q;

  // Pin synchronisers, two flops each
  logic [1:0]  pbSync_q;
  logic [1:0]  auxPinSync_q;
  logic [1:0]  vinSync_q;
  logic [1:0]  pgSync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pbSync_q     <= 2'h3;
      auxPinSync_q <= 2'h0;
      vinSync_q    <= 2'h0;
      pgSync_q     <= 2'h3;
    end else begin
      pbSync_q     <= {pbSync_q[0], pushButton_n};
      auxPinSync_q <= {auxPinSync_q[0], auxControlPin};
      vinSync_q    <= {vinSync_q[0], inputValid};
      pgSync_q     <= {pgSync_q[0], powerGood_n};
    end
  end

  wire pressed   = !pbSync_q[1];
  wire auxPin    = auxPinSync_q[1];
  wire vinOk     = vinSync_q[1];
  wire pgLevel_n = pgSync_q[1];

  // Address decode
  wire selSys = (regAddr == SYS_OUT_OFFSET);
  wire selAux = (regAddr == AUX_OUT_OFFSET);
  wire selPb  = (regAddr == PB_CTRL_OFFSET);
  wire wrSys  = regWrite && selSys;
  wire wrAux  = regWrite && selAux;
  wire wrPb   = regWrite && selPb;
  wire rdPb   = regRead && selPb;

  // Field views
  wire [1:0] sysRange   = sysOut_q[SYS_RANGE_LSB +: 2];
  wire [3:0] sysCode    = sysOut_q[SYS_CODE_LSB +: 4];
  wire       auxEnBit   = auxOut_q[AUX_ENABLE_BIT];
  wire [4:0] auxCode    = auxOut_q[AUX_CODE_LSB +: 5];
  wire       qualified  = auxOut_q[AUX_QUAL_BIT];
  wire       wake1Long  = pbCtrl_q[FIRST_WAKE_STATUS_SEL_BIT];
  wire       wake2Long  = pbCtrl_q[SECOND_WAKE_STATUS_SEL_BIT];
  wire       recoverHiz = pbCtrl_q[RECOVER_BIT];
  wire [1:0] resetSel   = pbCtrl_q[RESET_SEL_LSB +: 2];
  wire       pinFuncPb  = pbCtrl_q[PIN_FUNC_BIT];

  // Register writes; reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sysOut_q <= SYS_OUT_RESET & SYS_OUT_WMASK;
      auxOut_q <= AUX_OUT_RESET & AUX_OUT_WMASK;
      pbCtrl_q <= PB_CTRL_RESET & PB_CTRL_WMASK;
    end else begin
      if (wrSys)
        sysOut_q <= regWdata & SYS_OUT_WMASK;
      if (wrAux)
        auxOut_q <= regWdata & AUX_OUT_WMASK;
      if (wrPb)
        pbCtrl_q <= regWdata & PB_CTRL_WMASK;
    end
  end

  // Output is off only when both the bit and the pin say off
  wire auxOnNow = auxEnBit || auxPin;

  // Stored code reaches the regulator only while it is off; a code written
  // while on waits until the output is disabled again
  always_ff @(posedge clk) begin
    if (rst)
      auxApplied_q <= AUX_OUT_RESET[AUX_CODE_LSB +: 5];
    else if (!auxOnNow)
      auxApplied_q <= auxCode;
  end

  // Aux voltage: base plus 100 mV per code step
  wire [15:0] auxMv   = AUX_BASE_MV + 16'(auxApplied_q) * STEP_MV;
  wire        auxPass = (auxMv > AUX_PASS_MV);

  // System voltage; fractional ranges share one 83.3 mV ladder from 1250 mV
  wire [15:0] fracIndex = (sysRange == RANGE_FRAC) ? 16'(sysCode) + 16'h0003
                                                   : 16'(sysCode) - 16'h0002;
  wire [15:0] fracMv    = SYS_FRAC_BASE_MV + (fracIndex * SYS_FRAC_NUM + 16'h0001) / SYS_FRAC_DEN;
  wire [15:0] linMv     = 16'(sysCode) * STEP_MV;
  logic [15:0] sysMv;

  always_comb begin
    case (sysRange)
      RANGE_LOW: begin
        if (sysCode == 4'h0)
          sysMv = SYS_LOW0_MV;
        else if (sysCode == 4'h1)
          sysMv = SYS_LOW1_MV;
        else
          sysMv = fracMv;
      end
      RANGE_LINEAR: sysMv = SYS_LINEAR_MV + linMv;
      RANGE_FRAC:   sysMv = fracMv;
      RANGE_HIGH:   sysMv = SYS_HIGH_MV + linMv;
      default:      sysMv = SYS_LOW0_MV;
    endcase
  end

  // Millisecond tick, restarted at each press so intervals start at the edge
  localparam int TICK_W = $clog2(TICK_COUNT + 1);
  logic [TICK_W-1:0] tickCnt_q;
  logic              msTick_q;

  always_ff @(posedge clk) begin
    if (rst || !pressed) begin
      tickCnt_q <= '0;
      msTick_q  <= 1'b0;
    end else if (tickCnt_q == TICK_W'(TICK_COUNT - 1)) begin
      tickCnt_q <= '0;
      msTick_q  <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + TICK_W'(1);
      msTick_q  <= 1'b0;
    end
  end

  // Threshold selection
  wire [15:0] wake1Ms = wake1Long ? FIRST_WAKE_STATUS_LONG_MS : FIRST_WAKE_STATUS_SHORT_MS;
  wire [15:0] wake2Ms = wake2Long ? SECOND_WAKE_STATUS_LONG_MS : SECOND_WAKE_STATUS_SHORT_MS;
  logic [15:0] resetMs;

  always_comb begin
    case (resetSel)
      2'h0:    resetMs = RESET_5S_MS;
      2'h1:    resetMs = RESET_9S_MS;
      2'h2:    resetMs = RESET_11S_MS;
      2'h3:    resetMs = RESET_15S_MS;
      default: resetMs = RESET_5S_MS;
    endcase
  end

  // Three hold timers on the same press interval
  logic wake1Hit;
  logic wake2Hit;
  logic resetHit;

  hold_timer #(.CNT_W(16)) wake1Timer (
    .clk         (clk),
    .rst         (rst),
    .pressed     (pressed),
    .msTick      (msTick_q),
    .thresholdMs (wake1Ms),
    .reached     (wake1Hit)
  );

  hold_timer #(.CNT_W(16)) wake2Timer (
    .clk         (clk),
    .rst         (rst),
    .pressed     (pressed),
    .msTick      (msTick_q),
    .thresholdMs (wake2Ms),
    .reached     (wake2Hit)
  );

  hold_timer #(.CNT_W(16)) resetTimer (
    .clk         (clk),
    .rst         (rst),
    .pressed     (pressed),
    .msTick      (msTick_q),
    .thresholdMs (resetMs),
    .reached     (resetHit)
  );

  // Reset fires on hold time, gated by input window when qualified
  wire resetFire = resetHit && (!qualified || vinOk);

  // Wake status: a hit in the reading cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      wake1Stat_q <= 1'b0;
      wake2Stat_q <= 1'b0;
    end else begin
      wake1Stat_q <= wake1Hit || (wake1Stat_q && !rdPb);
      wake2Stat_q <= wake2Hit || (wake2Stat_q && !rdPb);
    end
  end

  // Read data mux; unmapped offsets read zero
  wire [7:0] pbView = {pbCtrl_q[7:2], wake1Stat_q, wake2Stat_q};
  wire [7:0] rdMux  = selSys ? sysOut_q :
                      selAux ? auxOut_q :
                      selPb  ? pbView   : 8'h00;

  always_ff @(posedge clk) begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= rdMux;
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      sharedPin_n     <= 1'b1;
      systemEnable    <= 1'b0;
      systemVoltageMv <= 16'h0000;
      auxOutputOn     <= 1'b0;
      auxVoltageMv    <= 16'h0000;
      auxPassThrough  <= 1'b0;
      pbReset         <= 1'b0;
      shipModeReq     <= 1'b0;
      hizModeReq      <= 1'b0;
    end else begin
      sharedPin_n     <= pinFuncPb ? pbSync_q[1] : pgLevel_n;
      systemEnable    <= sysOut_q[SYS_ENABLE_BIT];
      systemVoltageMv <= sysMv;
      auxOutputOn     <= auxOnNow;
      auxVoltageMv    <= auxMv;
      auxPassThrough  <= auxPass;
      pbReset         <= resetFire;
      shipModeReq     <= resetFire && !recoverHiz;
      hizModeReq      <= resetFire && recoverHiz;
    end
  end

endmodule
`default_nettype wire

// File: verification/pb_ldo_checker.sv
/*
  Output checker for the push-button and aux output register block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module pb_ldo_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        auxOutputOn,
  input wire logic [15:0] auxVoltageMv,
  input wire logic        auxPassThrough,
  input wire logic [15:0] systemVoltageMv,
  input wire logic        pbReset,
  input wire logic        shipModeReq,
  input wire logic        hizModeReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write to the system register selecting one range
  sequence sysWr(logic [1:0] r);
    regWrite && regAddr == 8'h06 && regWdata[6:5] == r;
  endsequence
  // Derived voltage lands two edges after the write
  a_sys_linear: assert property (sysWr(2'h1) |->
    ##2 systemVoltageMv == 16'h0514 + 16'h0064 * $past(regWdata[4:1], 2))
    else $error("range 01 voltage wrong");
  a_sys_high: assert property (sysWr(2'h3) |->
    ##2 systemVoltageMv == 16'h0708 + 16'h0064 * $past(regWdata[4:1], 2))
    else $error("range 11 voltage wrong");
  // Flag is registered in the same cycle as the voltage; judge only settled values
  a_pass_thru: assert property ($stable(auxVoltageMv) |-> auxPassThrough == (auxVoltageMv > 16'h0CE4))
    else $error("pass-through flag wrong");
  a_aux_step: assert property (auxVoltageMv != 16'h0000 |->
    auxVoltageMv >= 16'h0320 && auxVoltageMv <= 16'h0F3C &&
    (auxVoltageMv - 16'h0320) % 16'h0064 == 16'h0000)
    else $error("aux voltage off the code grid");
  a_aux_hold: assert property (auxOutputOn [*2] |=> $stable(auxVoltageMv))
    else $error("aux voltage changed while on");
  a_rd_hold: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  a_rd_unmapped: assert property (regRead && !(regAddr inside {8'h06, 8'h07, 8'h08}) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_pair: assert property (pbReset == (shipModeReq || hizModeReq) && !(shipModeReq && hizModeReq))
    else $error("mode request not paired with reset");
  a_reset_pulse: assert property (pbReset |=> !pbReset)
    else $error("reset pulse longer than one cycle");
endmodule
`default_nettype wire

// File: verification/button_model.sv
/*
  Push-button model: holds the pin low for a commanded number of cycles.
  Assumes start pulses come from the bench on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module button_model (
  input  wire logic        clk,
  input  wire logic        pressStart,
  input  wire logic [15:0] pressLen,
  output logic             pushButton_n
);
  logic [15:0] left_q = 16'h0000;
  // Pin has a pull-up, so a released button reads high
  always @(posedge clk) begin
    if (pressStart) left_q <= pressLen;
    else if (left_q != 16'h0000) left_q <= left_q - 16'h0001;
  end
  assign pushButton_n = (left_q == 16'h0000);
endmodule
`default_nettype wire

// File: verification/pushbutton_ldo_ctrl_regs_tb.sv
/*
  Bench for the push-button and aux output register block.
  Assumes TICK_COUNT 4, so one millisecond is four cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module pushbutton_ldo_ctrl_regs_tb;
  import pb_ldo_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, pressStart = 1'b0;
  logic        auxControlPin = 1'b0, inputValid = 1'b1, powerGood_n = 1'b1;
  logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [15:0] pressLen = 16'h0000, sysMv, auxMv;
  logic        pushButton_n, sharedPin_n, sysEn, auxOn, auxPass, pbReset, shipReq, hizReq;
  int          fails = 0, num_checks = 0, resets = 0, ships = 0, hizs = 0;
  always #4 clk = ~clk;
  pushbutton_ldo_ctrl_regs #(.TICK_COUNT(4)) u_pushbutton_ldo_ctrl_regs (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .pushButton_n(pushButton_n), .auxControlPin(auxControlPin), .inputValid(inputValid),
    .powerGood_n(powerGood_n), .sharedPin_n(sharedPin_n), .systemEnable(sysEn), .systemVoltageMv(sysMv),
    .auxOutputOn(auxOn), .auxVoltageMv(auxMv), .auxPassThrough(auxPass), .pbReset(pbReset),
    .shipModeReq(shipReq), .hizModeReq(hizReq));
  button_model u_button_model (.clk(clk), .pressStart(pressStart), .pressLen(pressLen),
    .pushButton_n(pushButton_n));
  // Pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (pbReset === 1'b1) resets <= resets + 1;
    if (shipReq === 1'b1) ships <= ships + 1;
    if (hizReq === 1'b1) hizs <= hizs + 1;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits past the derived-output update before returning
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(16'(regRdata), 16'(exp));
  endtask
  task automatic start(input logic [15:0] len);
    @(posedge clk);
    pressStart <= 1'b1;
    pressLen <= len;
    @(posedge clk);
    pressStart <= 1'b0;
  endtask
  task automatic press(input logic [15:0] len);
    start(len);
    repeat (int'(len) + 20) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rd(8'h06, 8'hAA);
    rd(8'h07, 8'h28);
    rd(8'h08, 8'h68);
    rd(8'h05, 8'h00);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'hFC);
    chk(16'(sysEn), 16'h0001);
    // Reset codes of both outputs land on 1800 mV
    chk(sysMv, 16'h0708);
    chk(auxMv, 16'h0708);
    $display("test regs done");
  endtask
  task automatic t_sys;
    wr(8'h06, 8'hBE);
    chk(sysMv, 16'h0AF0);
    wr(8'h06, 8'hFE);
    chk(sysMv, 16'h0CE4);
    wr(8'h06, 8'hDE);
    chk(sysMv, 16'h0ABE);
    wr(8'h06, 8'hC2);
    chk(sysMv, 16'h062F);
    // Range 00 fractional ladder, output disabled
    wr(8'h06, 8'h0C);
    chk(sysMv, 16'h062F);
    chk(16'(sysEn), 16'h0000);
    $display("test sys done");
  endtask
  // Host turns the output off before each code change, except where hold is probed
  task automatic t_aux;
    wr(8'h07, 8'h64);
    chk({auxPass, auxMv[14:0]}, 16'h0CE4);
    wr(8'h07, 8'h68);
    chk({auxPass, auxMv[14:0]}, 16'h8D48);
    wr(8'h07, 8'h84);
    chk({auxOn, auxMv[14:0]}, 16'h8D48);
    wr(8'h07, 8'h04);
    chk(auxMv, 16'h0384);
    @(posedge clk) auxControlPin <= 1'b1;
    wr(8'h07, 8'h08);
    chk(auxMv, 16'h0384);
    @(posedge clk) auxControlPin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(auxMv, 16'h03E8);
    $display("test aux done");
  endtask
  task automatic t_pin;
    wr(8'h08, 8'h00);
    @(posedge clk) powerGood_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(16'(sharedPin_n), 16'h0000);
    @(posedge clk) powerGood_n <= 1'b1;
    wr(8'h08, 8'h04);
    chk(16'(sharedPin_n), 16'h0001);
    start(16'h001E);
    repeat (10) @(posedge clk);
    #1;
    chk(16'(sharedPin_n), 16'h0000);
    repeat (30) @(posedge clk);
    $display("test pin done");
  endtask
  task automatic t_wake;
    wr(8'h08, 8'h00);
    press(16'h012C);
    press(16'h012C);
    rd(8'h08, 8'h00);
    press(16'h0190);
    rd(8'h08, 8'h02);
    rd(8'h08, 8'h00);
    wr(8'h08, 8'h80);
    press(16'h0190);
    rd(8'h08, 8'h80);
    press(16'h09C4);
    rd(8'h08, 8'h82);
    press(16'h1004);
    rd(8'h08, 8'h83);
    wr(8'h08, 8'hC0);
    press(16'h1004);
    rd(8'h08, 8'hC2);
    $display("test wake done");
  endtask
  task automatic t_reset;
    wr(8'h07, 8'h01);
    wr(8'h08, 8'h20);
    @(posedge clk) inputValid <= 1'b0;
    press(16'h4E84);
    chk(16'(resets), 16'h0000);
    @(posedge clk) inputValid <= 1'b1;
    press(16'h4E84);
    chk(16'(hizs), 16'h0001);
    wr(8'h08, 8'h00);
    wr(8'h07, 8'h00);
    @(posedge clk) inputValid <= 1'b0;
    press(16'h4E84);
    chk(16'(ships), 16'h0001);
    chk(16'(resets), 16'h0002);
    $display("test reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sys();
    t_aux();
    t_pin();
    t_wake();
    t_reset();
    tally_and_finish();
  end
  // Whole run is about 73000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
bind pushbutton_ldo_ctrl_regs pb_ldo_checker u_pb_ldo_checker (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .auxOutputOn(auxOutputOn),
  .auxVoltageMv(auxVoltageMv), .auxPassThrough(auxPassThrough), .systemVoltageMv(systemVoltageMv),
  .pbReset(pbReset), .shipModeReq(shipModeReq), .hizModeReq(hizModeReq));
`default_nettype wire
